// *** rtl/affi_pkg.sv ***
package affi_pkg;
    // Opcodes
    localparam logic [7:0] OP_FLUSH = 8'hE7;
    localparam logic [7:0] OP_FORMAT = 8'h50;
    localparam logic [7:0] OP_IDENT = 8'hEC;
    // Task-file register offsets on the register port
    localparam logic [3:0] OFF_FEATURE = 4'h1;
    localparam logic [3:0] OFF_SCOUNT = 4'h2;
    localparam logic [3:0] OFF_SNUM = 4'h3;
    localparam logic [3:0] OFF_CYL_LO = 4'h4;
    localparam logic [3:0] OFF_CYL_HI = 4'h5;
    localparam logic [3:0] OFF_DRVHD = 4'h6;
    localparam logic [3:0] OFF_CMD_STAT = 4'h7;
    localparam logic [3:0] OFF_ERROR = 4'h8;
    localparam logic [3:0] OFF_DATA = 4'h9;
    localparam logic [3:0] OFF_FMT_LBA_LO = 4'hA;
    localparam logic [3:0] OFF_FMT_LBA_HI = 4'hB;
    localparam logic [3:0] OFF_FMT_CNT = 4'hC;
    // Drive/head field positions
    localparam int DH_DRV = 4;
    localparam int DH_LBA = 6;
    // Status and error bits
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_SEEK_COMPLETE = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    // Fixed identify words, fill pattern, sector and page sizes, reset status
    localparam logic [15:0] ID_W5 = 16'h0200;
    localparam logic [15:0] ID_W20 = 16'h0002;
    localparam logic [15:0] ID_W21 = 16'h0002;
    localparam logic [15:0] ID_W22 = 16'h0004;
    localparam logic [15:0] ID_W47_BASE = 16'h8000;
    localparam logic [15:0] ID_W49_DMA = 16'h0F00;
    localparam logic [15:0] ID_W49_NODMA = 16'h0E00;
    localparam logic [7:0] FILL_PATTERN = 8'hFF;
    localparam logic [8:0] SECTORS_ZERO = 9'h100;
    localparam logic [8:0] PAGE_WORDS = 9'h100;
    localparam logic [7:0] STAT_RESET = 8'h50;

    typedef enum {AFFI_IDLE, AFFI_FLUSH, AFFI_ID_BUILD, AFFI_ID_XFER, AFFI_FMT_RX, AFFI_FMT_WR} affi_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } affi_req_t;

    typedef struct packed {
        logic req;
        logic [27:0] lba;
        logic [8:0] count;
        logic [7:0] pattern;
    } affi_fmt_t;
endpackage

// *** rtl/affi_cmd.sv ***
`timescale 1ns/1ns
// Function
// - Flush waits until the write cache reports every pending byte committed.
// - Flush completes with ready and seek-complete set only after commit.
// - Without flush support the opcode ends with an aborted-command error.
// - Format overwrites the selected track with a fixed fill pattern.
// - Format takes one sector buffer like a write and discards it.
// - In LBA mode format covers sector-count sectors, zero meaning 256.
// - Identify returns one sector through the sector-read handshake.
// - Reserved bits and words of the identify page read as zero.
// - Drive/head: bit 4 drive, bit 6 LBA, bits 3-0 head or LBA 27-24.
// - In LBA mode cylinder high is LBA 23-16, cylinder low LBA 15-8.
// - Word 0 holds a configuration signature, removable or fixed.
// - Words 7-8 hold total sectors, word 7 the high half.
// - Words 10-19 hold the right-justified twenty-byte serial string.
// - Words 23-26 hold the firmware string, first character in high byte.
// - Words 27-46 hold the right-justified model string, high byte first.
// - Word 47 low digit is 1 for one flash, 2 for more.
// - Word 49 reports capabilities with or without DMA.
// - Words 1, 3 and 6 hold cylinders, heads and sectors per track.
module affi_cmd #(
    parameter logic FLUSH_SUPPORT = 1'b1,
    parameter logic DMA_AVAIL = 1'b1,
    parameter logic MULTI_FLASH = 1'b0,
    parameter logic [15:0] CFG_REMOVABLE = 16'h1234, // Arbitrary value
    parameter logic [15:0] CFG_FIXED = 16'h5678, // Arbitrary value
    parameter logic [15:0] CYLINDERS = 16'h0100,
    parameter logic [15:0] HEADS = 16'h0010,
    parameter logic [15:0] SPT = 16'h0020,
    parameter logic [31:0] TOTAL_SECTORS = 32'h0002_0000,
    parameter logic [159:0] SERIAL = {20{8'h30}},
    parameter logic [63:0] FW_REV = {8{8'h31}},
    parameter logic [319:0] MODEL = {40{8'h41}}
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire affi_pkg::affi_req_t req_i,
    output logic [15:0] rdata_o,
    input wire logic removable_i,
    input wire logic cache_empty_i,
    output logic cache_flush_o,
    output affi_pkg::affi_fmt_t fmt_o,
    input wire logic fmt_done_i,
    output logic drq_o,
    output logic busy_o
);
    affi_pkg::affi_state_t state_reg, state_next;
    logic [15:0] page [0:255];
    logic [7:0] feature_reg;
    logic [7:0] scount_reg;
    logic [7:0] snum_reg;
    logic [7:0] cyl_lo_reg;
    logic [7:0] cyl_hi_reg;
    logic [7:0] drvhd_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] error_reg;
    logic [7:0] error_next;
    logic [15:0] rdata_reg;
    logic [8:0] ptr_reg, ptr_next;
    logic [27:0] fmt_lba_reg;
    logic [8:0] fmt_cnt_reg;
    logic fmt_req_reg;
    logic [15:0] id_word;
    logic rem_meta_reg;
    logic rem_sync_reg;

    // Register port address decode
    wire sel_feature = req_i.addr == affi_pkg::OFF_FEATURE;
    wire sel_scount = req_i.addr == affi_pkg::OFF_SCOUNT;
    wire sel_snum = req_i.addr == affi_pkg::OFF_SNUM;
    wire sel_cyl_lo = req_i.addr == affi_pkg::OFF_CYL_LO;
    wire sel_cyl_hi = req_i.addr == affi_pkg::OFF_CYL_HI;
    wire sel_drvhd = req_i.addr == affi_pkg::OFF_DRVHD;
    wire sel_cmd_stat = req_i.addr == affi_pkg::OFF_CMD_STAT;
    wire sel_error = req_i.addr == affi_pkg::OFF_ERROR;
    wire sel_data = req_i.addr == affi_pkg::OFF_DATA;
    wire sel_lba_lo = req_i.addr == affi_pkg::OFF_FMT_LBA_LO;
    wire sel_lba_hi = req_i.addr == affi_pkg::OFF_FMT_LBA_HI;
    wire sel_fmt_cnt = req_i.addr == affi_pkg::OFF_FMT_CNT;
    wire tf_wr = req_i.wr && state_reg == affi_pkg::AFFI_IDLE;

    wire cmd_wr = tf_wr && sel_cmd_stat;
    wire [7:0] opcode = req_i.wdata[7:0];
    wire data_rd = req_i.rd && sel_data && state_reg == affi_pkg::AFFI_ID_XFER;
    wire data_wr = req_i.wr && sel_data && state_reg == affi_pkg::AFFI_FMT_RX;
    wire lba_mode = drvhd_reg[affi_pkg::DH_LBA];
    wire drive_sel = drvhd_reg[affi_pkg::DH_DRV];
    wire [27:0] start_lba = {drvhd_reg[3:0], cyl_hi_reg, cyl_lo_reg, snum_reg};
    wire [27:0] chs_addr = {drvhd_reg[3:0], cyl_hi_reg, cyl_lo_reg, 8'h00};
    wire [8:0] fmt_count = (scount_reg == 8'h00) ? affi_pkg::SECTORS_ZERO : {1'b0, scount_reg};
    wire [7:0] wi = ptr_reg[7:0];
    wire [4:0] si = 5'(wi - 8'd10);
    wire [4:0] fi = 5'(wi - 8'd23);
    wire [5:0] mi = 6'(wi - 8'd27);

    // Identify word for the build pointer; unlisted words stay zero
    always_comb begin
        id_word = 16'h0000;
        if (wi == 8'd0) begin
            id_word = rem_sync_reg ? CFG_REMOVABLE : CFG_FIXED;
        end else if (wi == 8'd1) begin
            id_word = CYLINDERS;
        end else if (wi == 8'd3) begin
            id_word = HEADS;
        end else if (wi == 8'd5) begin
            id_word = affi_pkg::ID_W5;
        end else if (wi == 8'd6) begin
            id_word = SPT;
        end else if (wi == 8'd7) begin
            id_word = TOTAL_SECTORS[31:16];
        end else if (wi == 8'd8) begin
            id_word = TOTAL_SECTORS[15:0];
        end else if (wi >= 8'd10 && wi <= 8'd19) begin
            id_word = SERIAL[159 - 16 * si -: 16];
        end else if (wi == 8'd20) begin
            id_word = affi_pkg::ID_W20;
        end else if (wi == 8'd21) begin
            id_word = affi_pkg::ID_W21;
        end else if (wi == 8'd22) begin
            id_word = affi_pkg::ID_W22;
        end else if (wi >= 8'd23 && wi <= 8'd26) begin
            id_word = FW_REV[63 - 16 * fi -: 16];
        end else if (wi >= 8'd27 && wi <= 8'd46) begin
            id_word = MODEL[319 - 16 * mi -: 16];
        end else if (wi == 8'd47) begin
            id_word = affi_pkg::ID_W47_BASE | (MULTI_FLASH ? 16'h0002 : 16'h0001);
        end else if (wi == 8'd49) begin
            id_word = (DMA_AVAIL && !rem_sync_reg) ? affi_pkg::ID_W49_DMA : affi_pkg::ID_W49_NODMA;
        end
    end

    // Command sequencer
    always_comb begin
        state_next = state_reg;
        status_next = status_reg;
        error_next = error_reg;
        ptr_next = ptr_reg;
        case (state_reg)
            affi_pkg::AFFI_IDLE: begin
                if (cmd_wr) begin
                    error_next = 8'h00;
                    status_next = 8'h00;
                    status_next[affi_pkg::ST_BSY] = 1'b1;
                    ptr_next = 9'h000;
                    if (opcode == affi_pkg::OP_FLUSH && FLUSH_SUPPORT) begin
                        state_next = affi_pkg::AFFI_FLUSH;
                    end else if (opcode == affi_pkg::OP_IDENT) begin
                        state_next = affi_pkg::AFFI_ID_BUILD;
                    end else if (opcode == affi_pkg::OP_FORMAT) begin
                        state_next = affi_pkg::AFFI_FMT_RX;
                        status_next = 8'h00;
                        status_next[affi_pkg::ST_DRQ] = 1'b1;
                    end else begin
                        error_next = affi_pkg::ERR_ABORT;
                        status_next = 8'h00;
                        status_next[affi_pkg::ST_RDY] = 1'b1;
                        status_next[affi_pkg::ST_ERR] = 1'b1;
                    end
                end
            end
            affi_pkg::AFFI_FLUSH: begin
                if (cache_empty_i) begin
                    state_next = affi_pkg::AFFI_IDLE;
                    status_next = 8'h00;
                    status_next[affi_pkg::ST_RDY] = 1'b1;
                    status_next[affi_pkg::ST_SEEK_COMPLETE] = 1'b1;
                end
            end
            affi_pkg::AFFI_ID_BUILD: begin
                ptr_next = ptr_reg + 9'h001;
                if (ptr_reg == affi_pkg::PAGE_WORDS - 9'h001) begin
                    state_next = affi_pkg::AFFI_ID_XFER;
                    ptr_next = 9'h000;
                    status_next = 8'h00;
                    status_next[affi_pkg::ST_RDY] = 1'b1;
                    status_next[affi_pkg::ST_SEEK_COMPLETE] = 1'b1;
                    status_next[affi_pkg::ST_DRQ] = 1'b1;
                end
            end
            affi_pkg::AFFI_ID_XFER: begin
                if (data_rd) begin
                    ptr_next = ptr_reg + 9'h001;
                    if (ptr_reg == affi_pkg::PAGE_WORDS - 9'h001) begin
                        state_next = affi_pkg::AFFI_IDLE;
                        status_next[affi_pkg::ST_DRQ] = 1'b0;
                    end
                end
            end
            affi_pkg::AFFI_FMT_RX: begin
                if (data_wr) begin
                    ptr_next = ptr_reg + 9'h001;
                    if (ptr_reg == affi_pkg::PAGE_WORDS - 9'h001) begin
                        state_next = affi_pkg::AFFI_FMT_WR;
                        status_next = 8'h00;
                        status_next[affi_pkg::ST_BSY] = 1'b1;
                    end
                end
            end
            affi_pkg::AFFI_FMT_WR: begin
                if (fmt_done_i && !fmt_req_reg) begin
                    state_next = affi_pkg::AFFI_IDLE;
                    status_next = 8'h00;
                    status_next[affi_pkg::ST_RDY] = 1'b1;
                    status_next[affi_pkg::ST_SEEK_COMPLETE] = 1'b1;
                end
            end
            default: begin
                state_next = affi_pkg::AFFI_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= affi_pkg::AFFI_IDLE;
            status_reg <= affi_pkg::STAT_RESET;
            error_reg <= 8'h00;
            ptr_reg <= 9'h000;
        end else begin
            state_reg <= state_next;
            status_reg <= status_next;
            error_reg <= error_next;
            ptr_reg <= ptr_next;
        end
    end

    // Mode pin passes two flip-flops before use
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rem_meta_reg <= 1'b0;
            rem_sync_reg <= 1'b0;
        end else begin
            rem_meta_reg <= removable_i;
            rem_sync_reg <= rem_meta_reg;
        end
    end

    // Page assembly; memory has no reset
    always_ff @(posedge mclk_i) begin
        if (state_reg == affi_pkg::AFFI_ID_BUILD) begin
            page[wi] <= id_word;
        end
    end

    // Task-file registers, written only while idle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            feature_reg <= 8'h00;
            scount_reg <= 8'h01;
            snum_reg <= 8'h01;
            cyl_lo_reg <= 8'h00;
            cyl_hi_reg <= 8'h00;
            drvhd_reg <= 8'h00;
        end else if (tf_wr) begin
            if (sel_feature) begin
                feature_reg <= req_i.wdata[7:0];
            end else if (sel_scount) begin
                scount_reg <= req_i.wdata[7:0];
            end else if (sel_snum) begin
                snum_reg <= req_i.wdata[7:0];
            end else if (sel_cyl_lo) begin
                cyl_lo_reg <= req_i.wdata[7:0];
            end else if (sel_cyl_hi) begin
                cyl_hi_reg <= req_i.wdata[7:0];
            end else if (sel_drvhd) begin
                drvhd_reg <= req_i.wdata[7:0];
            end
        end
    end

    // Format request to the media side, issued once the buffer is discarded
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fmt_req_reg <= 1'b0;
            fmt_lba_reg <= 28'h0000000;
            fmt_cnt_reg <= 9'h000;
        end else begin
            fmt_req_reg <= state_reg == affi_pkg::AFFI_FMT_RX && state_next == affi_pkg::AFFI_FMT_WR;
            if (state_reg == affi_pkg::AFFI_FMT_RX && state_next == affi_pkg::AFFI_FMT_WR) begin
                fmt_lba_reg <= lba_mode ? start_lba : chs_addr;
                fmt_cnt_reg <= lba_mode ? fmt_count : {1'b0, SPT[7:0]};
            end
        end
    end

    // Register read path, data one cycle after the strobe
    wire [15:0] rd_mux =
        sel_feature ? {8'h00, feature_reg} :
        sel_scount ? {8'h00, scount_reg} :
        sel_snum ? {8'h00, snum_reg} :
        sel_cyl_lo ? {8'h00, cyl_lo_reg} :
        sel_cyl_hi ? {8'h00, cyl_hi_reg} :
        sel_drvhd ? {8'h00, drvhd_reg} :
        sel_cmd_stat ? {8'h00, status_reg} :
        sel_error ? {8'h00, error_reg} :
        data_rd ? page[wi] :
        sel_lba_lo ? fmt_lba_reg[15:0] :
        sel_lba_hi ? {3'b000, drive_sel, fmt_lba_reg[27:16]} :
        sel_fmt_cnt ? {7'h00, fmt_cnt_reg} :
        16'h0000;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 16'h0000;
        end else if (req_i.rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata_o = rdata_reg;
    assign cache_flush_o = state_reg == affi_pkg::AFFI_FLUSH;
    assign fmt_o = '{req: fmt_req_reg, lba: fmt_lba_reg, count: fmt_cnt_reg, pattern: affi_pkg::FILL_PATTERN};
    assign drq_o = status_reg[affi_pkg::ST_DRQ];
    assign busy_o = status_reg[affi_pkg::ST_BSY];
endmodule

// *** test/affi_cmd_props.sv ***
`timescale 1ns/1ns
module affi_chk #(
    parameter logic FLUSH_SUPPORT = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire affi_pkg::affi_req_t req_i,
    input wire logic [15:0] rdata_o,
    input wire logic cache_empty_i,
    input wire logic cache_flush_o,
    input wire affi_pkg::affi_fmt_t fmt_o,
    input wire logic drq_o,
    input wire logic busy_o
);
    logic [7:0] sc_reg, cl_reg, ch_reg, dh_reg;
    wire idle = !busy_o && !drq_o;
    wire cmd_wr = idle && req_i.wr && req_i.addr == affi_pkg::OFF_CMD_STAT;
    wire flush_cmd = cmd_wr && req_i.wdata[7:0] == affi_pkg::OP_FLUSH;
    wire id_cmd = cmd_wr && req_i.wdata[7:0] == affi_pkg::OP_IDENT;
    wire fmt_cmd = cmd_wr && req_i.wdata[7:0] == affi_pkg::OP_FORMAT;
    wire [8:0] sc_exp = sc_reg == 8'h00 ? affi_pkg::SECTORS_ZERO : {1'b0, sc_reg};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Shadow of the task file, written only while idle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {sc_reg, cl_reg, ch_reg, dh_reg} <= {8'h01, 24'h000000};
        end else if (idle && req_i.wr) begin
            case (req_i.addr)
                affi_pkg::OFF_SCOUNT: sc_reg <= req_i.wdata[7:0];
                affi_pkg::OFF_CYL_LO: cl_reg <= req_i.wdata[7:0];
                affi_pkg::OFF_CYL_HI: ch_reg <= req_i.wdata[7:0];
                affi_pkg::OFF_DRVHD: dh_reg <= req_i.wdata[7:0];
                default: ;
            endcase
        end
    end
    a_read_answer: assert property (rdata_o != 16'h0000 |-> $past(req_i.rd))
        else $error("read data outside a read answer");
    a_flush_start: assert property (flush_cmd |=> busy_o == FLUSH_SUPPORT && cache_flush_o == FLUSH_SUPPORT)
        else $error("flush start wrong");
    a_flush_hold: assert property (cache_flush_o && !cache_empty_i |=> cache_flush_o && busy_o)
        else $error("flush ended with cache pending");
    a_flush_end: assert property (cache_flush_o && cache_empty_i |=> !cache_flush_o && !busy_o)
        else $error("flush not completed");
    a_id_page: assert property (id_cmd |=> busy_o [*8] ##248 busy_o ##1 (drq_o && !busy_o))
        else $error("identify page timing wrong");
    a_fmt_buffer: assert property (fmt_cmd |=> drq_o && !busy_o)
        else $error("format buffer not requested");
    a_fmt_pulse: assert property (fmt_o.req |-> busy_o && fmt_o.pattern == affi_pkg::FILL_PATTERN ##1 !fmt_o.req)
        else $error("format request wrong");
    a_fmt_count: assert property (fmt_o.req && dh_reg[affi_pkg::DH_LBA] |-> fmt_o.count == sc_exp)
        else $error("format count wrong");
    a_fmt_addr: assert property (fmt_o.req |-> fmt_o.lba[27:8] == {dh_reg[3:0], ch_reg, cl_reg})
        else $error("format address wrong");
endmodule

bind affi_cmd affi_chk #(.FLUSH_SUPPORT(FLUSH_SUPPORT)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .cache_empty_i(cache_empty_i), .cache_flush_o(cache_flush_o), .fmt_o(fmt_o),
    .drq_o(drq_o), .busy_o(busy_o));

// *** test/affi_media.sv ***
`timescale 1ns/1ns
module affi_media (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] dly_i,
    input wire logic cache_flush_i,
    input wire affi_pkg::affi_fmt_t fmt_i,
    output logic cache_empty_o,
    output logic fmt_done_o
);
    logic [7:0] fl_cnt_reg, fm_cnt_reg;
    logic fm_run_reg;
    // Cache stays dirty for dly_i cycles of flushing
    assign cache_empty_o = !cache_flush_i || fl_cnt_reg >= dly_i;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fl_cnt_reg <= 8'h00;
            fm_cnt_reg <= 8'h00;
            fm_run_reg <= 1'b0;
            fmt_done_o <= 1'b0;
        end else begin
            fl_cnt_reg <= cache_flush_i ? fl_cnt_reg + 8'h01 : 8'h00;
            fm_cnt_reg <= fm_run_reg ? fm_cnt_reg + 8'h01 : 8'h00;
            fm_run_reg <= fmt_i.req || (fm_run_reg && fm_cnt_reg != dly_i);
            fmt_done_o <= fm_run_reg && fm_cnt_reg == dly_i;
        end
    end
endmodule

// *** test/tb_affi_cmd.sv ***
`timescale 1ns/1ns
module tb_affi_cmd;
    localparam logic [159:0] SER = {{8{8'h20}}, "SER-0042ABCD"};
    localparam logic [63:0] FW = "REV1.23A";
    localparam logic [319:0] MDL = {{30{8'h20}}, "MODEL-7731"};
    localparam logic [15:0] CFG_R = 16'h1A2B; // Arbitrary value
    localparam logic [15:0] CFG_F = 16'h3C4D; // Arbitrary value
    localparam logic [31:0] TOT = 32'h0007_A0F8;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic removable_i = 1'b0;
    logic [7:0] dly = 8'h01;
    affi_pkg::affi_req_t req_i = '0;
    logic [15:0] rdata_o, rdata2, rv;
    logic cache_empty_i, cache_flush_o, fmt_done_i, drq_o, busy_o;
    affi_pkg::affi_fmt_t fmt_o;
    logic [31:0] seed = 32'h0D0D;
    int err_total = 0;
    int n_compared = 0;
    always #4 mclk_i = ~mclk_i;
    affi_cmd #(.MULTI_FLASH(1'b1), .CFG_REMOVABLE(CFG_R), .CFG_FIXED(CFG_F), .CYLINDERS(16'h03C1),
        .HEADS(16'h0008), .SPT(16'h003F), .TOTAL_SECTORS(TOT), .SERIAL(SER), .FW_REV(FW), .MODEL(MDL)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .removable_i(removable_i),
        .cache_empty_i(cache_empty_i), .cache_flush_o(cache_flush_o), .fmt_o(fmt_o), .fmt_done_i(fmt_done_i),
        .drq_o(drq_o), .busy_o(busy_o));
    affi_cmd #(.FLUSH_SUPPORT(1'b0)) dut2 (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata2),
        .removable_i(removable_i), .cache_empty_i(cache_empty_i), .cache_flush_o(), .fmt_o(),
        .fmt_done_i(fmt_done_i), .drq_o(), .busy_o());
    affi_media u_media (.mclk_i(mclk_i), .rst_i(rst_i), .dly_i(dly), .cache_flush_i(cache_flush_o),
        .fmt_i(fmt_o), .cache_empty_o(cache_empty_i), .fmt_done_o(fmt_done_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] id_word(input int w, input logic rem);
        if (w >= 10 && w <= 19) return SER[(159 - 16 * (w - 10)) -: 16];
        if (w >= 23 && w <= 26) return FW[(63 - 16 * (w - 23)) -: 16];
        if (w >= 27 && w <= 46) return MDL[(319 - 16 * (w - 27)) -: 16];
        case (w)
            0: return rem ? CFG_R : CFG_F;
            1: return 16'h03C1;
            3: return 16'h0008;
            5: return affi_pkg::ID_W5;
            6: return 16'h003F;
            7: return TOT[31:16];
            8: return TOT[15:0];
            20: return affi_pkg::ID_W20;
            21: return affi_pkg::ID_W21;
            22: return affi_pkg::ID_W22;
            47: return affi_pkg::ID_W47_BASE | 16'h0002;
            49: return rem ? affi_pkg::ID_W49_NODMA : affi_pkg::ID_W49_DMA;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        req_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        req_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        req_i.rd <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_stat(input logic [15:0] exp, input string msg);
        int n;
        n = 0;
        rd(affi_pkg::OFF_CMD_STAT, rv);
        while (rv !== exp && n < 500) begin
            rd(affi_pkg::OFF_CMD_STAT, rv);
            n++;
        end
        chk(rv, exp, msg);
        if (rv !== exp) end_sim();
    endtask
    initial begin
        int i, k;
        logic [31:0] r;
        logic [7:0] sc, dh;
        logic [8:0] ec;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            dly <= i ? 8'h28 : 8'h01;
            wr(affi_pkg::OFF_CMD_STAT, {8'h00, affi_pkg::OP_FLUSH});
            rd(affi_pkg::OFF_CMD_STAT, rv);
            if (i == 1) chk(rv, 16'h0080, "flush busy");
            chk(rdata2, 16'h0041, "no flush support");
            rd(affi_pkg::OFF_ERROR, rv);
            chk(rdata2, 16'h0004, "abort error");
            wait_stat(16'h0050, "flush done");
        end
        $display("flush test done");
        for (i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            removable_i <= i[0];
            wr(affi_pkg::OFF_CMD_STAT, {8'h00, affi_pkg::OP_IDENT});
            wait_stat(16'h0058, "page ready");
            for (k = 0; k < 256; k++) begin
                rd(affi_pkg::OFF_DATA, rv);
                if (k <= 50) chk(rv, id_word(k, i[0]), "page word");
            end
            wait_stat(16'h0050, "page read out");
        end
        $display("identify test done");
        for (i = 0; i < 3; i++) begin
            r = rnd();
            sc = i == 0 ? 8'h00 : r[31:24];
            dh = {1'b0, i < 2, 1'b0, r[4:0]};
            wr(affi_pkg::OFF_DRVHD, {8'h00, dh});
            wr(affi_pkg::OFF_CYL_HI, {8'h00, r[15:8]});
            wr(affi_pkg::OFF_CYL_LO, {8'h00, r[23:16]});
            wr(affi_pkg::OFF_SNUM, {8'h00, r[7:0]});
            wr(affi_pkg::OFF_SCOUNT, {8'h00, sc});
            dly <= {3'h0, r[29:25]};
            wr(affi_pkg::OFF_CMD_STAT, {8'h00, affi_pkg::OP_FORMAT});
            wait_stat(16'h0008, "buffer request");
            for (k = 0; k < 256; k++) wr(affi_pkg::OFF_DATA, 16'(rnd() >> 16));
            k = 0;
            while (fmt_o.req !== 1'b1 && k < 100) begin
                @(negedge mclk_i);
                k++;
            end
            chk({15'h0000, fmt_o.req}, 16'h0001, "format request");
            if (k >= 100) end_sim();
            ec = dh[6] ? (sc == 8'h00 ? 9'h100 : {1'b0, sc}) : 9'h03F;
            chk({7'h00, fmt_o.count}, {7'h00, ec}, "format count");
            chk(fmt_o.lba[27:12], {dh[3:0], r[15:8], r[23:20]}, "format address");
            chk({4'h0, fmt_o.lba[11:0]}, {4'h0, r[19:16], dh[6] ? r[7:0] : 8'h00}, "format low");
            chk({8'h00, fmt_o.pattern}, {8'h00, affi_pkg::FILL_PATTERN}, "fill pattern");
            wait_stat(16'h0050, "format done");
        end
        rd(4'hF, rv);
        chk(rv, 16'h0000, "unmapped read");
        $display("format test done");
        end_sim();
    end
endmodule
